/* vc0_resource_config_regs_bench.sv */
// self-checking bench for the channel-zero resource register bank
// assumes vcr_regs holds its own table loader and one 20 MHz clock
`timescale 1ns/1ps
`default_nettype none
module vc0_resource_config_regs_bench;
  import vcr_pkg::*;

  // ==========================================================
  // stimulus and observation signals
  logic              sys_clk;               // 20 MHz core clock
  logic              arst_n;                // async reset, active low
  logic [ADDR_W-1:0] avs_address;           // byte address
  logic              avs_read;              // read request
  logic              avs_write;             // write request
  logic [3:0]        avs_byteenable;        // write lanes
  logic [DATA_W-1:0] avs_writedata;         // write data
  logic [DATA_W-1:0] avs_readdata;          // read data
  logic              avs_waitrequest;       // slave stall
  logic              arb_table_write;       // table entry written
  logic              negotiating;           // negotiation level
  logic              eeprom_load_valid;     // eeprom load pulse
  logic [6:0]        eeprom_time_slots;     // eeprom slot value
  logic [7:0]        class_to_channel_map;  // map output
  logic [2:0]        arb_select;            // select output
  logic              channel_zero_enable;   // enable output
  logic              table_load_start;      // load pulse
  logic              table_loading;         // loader busy
  int                n_errors;              // mismatches
  int                check_count;           // comparisons
  int                cyc;                   // timeout counter
  logic [31:0]       d;                     // last read word

  vcr_regs i_vcr_regs (
    .sys_clk              (sys_clk),
    .arst_n               (arst_n),
    .avs_address          (avs_address),
    .avs_read             (avs_read),
    .avs_write            (avs_write),
    .avs_byteenable       (avs_byteenable),
    .avs_writedata        (avs_writedata),
    .avs_readdata         (avs_readdata),
    .avs_waitrequest      (avs_waitrequest),
    .arb_table_write      (arb_table_write),
    .negotiating          (negotiating),
    .eeprom_load_valid    (eeprom_load_valid),
    .eeprom_time_slots    (eeprom_time_slots),
    .class_to_channel_map (class_to_channel_map),
    .arb_select           (arb_select),
    .channel_zero_enable  (channel_zero_enable),
    .table_load_start     (table_load_start),
    .table_loading        (table_loading)
  );

  // ==========================================================
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // whole run is a few hundred cycles, so 20000 means a hang
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("CHECK FAILED t=%0t run timed out", $time);
      end_sim();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one compare for every result, flags zero-extended
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    rd = '0;
    @(posedge sys_clk);
    avs_address    <= a;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    // pre-edge stall value decides; only the run guard ends a wait
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    // answer edge: read word taken, write lands, request released
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd,
                    input logic [3:0] be);
    logic [31:0] x;
    bus(1'b1, a, wd, be, x);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] x);
    bus(1'b0, a, 32'h0, 4'hF, x);
  endtask

  // reset held five cycles, released on a rising edge
  task automatic do_reset();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_values();
    @(negedge sys_clk);
    chk({class_to_channel_map, arb_select, channel_zero_enable,
         table_load_start, table_loading}, {8'hFF, 3'h0, 3'b100}, "rst out");
    rd(OFS_CAP, d);
    chk(d, 32'h047F0019, "cap rst");
    rd(OFS_CTL, d);
    chk(d, 32'h800000FF, "ctl rst");
    rd(OFS_STS, d);
    chk(d, 32'h0, "sts rst");
  endtask

  // read-only words and unmapped places refuse writes
  task automatic t_read_only();
    wr(OFS_CAP, 32'hFFFFFFFF, 4'hF);
    rd(OFS_CAP, d);
    chk(d, 32'h047F0019, "cap ro");
    wr(OFS_STS, 32'hFFFFFFFF, 4'hF);
    rd(OFS_STS, d);
    chk(d, 32'h0, "sts ro");
    wr(12'h15C, 32'hFFFFFFFF, 4'hF);
    rd(12'h15C, d);
    chk(d, 32'h0, "unmapped");
    rd(12'h151, d);
    chk(d, 32'h0, "misaligned");
  endtask

  // every select code, reserved and id bits written as ones
  task automatic t_select();
    logic [2:0] e;
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CTL, {1'b1, 11'h7FF, i[2:0], 1'b0, 8'hFF, 8'hA5}, 4'hF);
      e = (i == 3) ? SEL_WRR : SEL_DEFAULT;
      rd(OFS_CTL, d);
      chk(d, {1'b1, 11'h0, e, 1'b0, 8'h00, 8'hA5}, "ctl word");
      chk({arb_select, class_to_channel_map}, {e, 8'hA5}, "sel out");
    end
  endtask

  // lanes with enable low keep their fields
  task automatic t_lanes();
    wr(OFS_CTL, 32'h00000000, 4'h1);
    rd(OFS_CTL, d);
    chk(d, 32'h80000000, "lane0");
    wr(OFS_CTL, 32'h00000000, 4'h8);
    rd(OFS_CTL, d);
    chk(d, 32'h00000000, "lane3");
    chk(channel_zero_enable, 1'b0, "en out");
    wr(OFS_CTL, 32'h80060055, 4'hD);
    // fields update at the answer edge, so look once they settle
    @(negedge sys_clk);
    chk({channel_zero_enable, arb_select, class_to_channel_map},
        {1'b1, 3'h3, 8'h55}, "ctl out");
  endtask

  // pending set by a table write, cleared after a full load
  task automatic t_table_load();
    int n;
    n = 0;
    @(posedge sys_clk);
    arb_table_write <= 1'b1;
    @(posedge sys_clk);
    arb_table_write <= 1'b0;
    rd(OFS_STS, d);
    chk(d, 32'h00010000, "pend set");
    wr(OFS_CTL, 32'h80070055, 4'hF);
    @(negedge sys_clk);
    chk(table_load_start, 1'b1, "start");
    for (int k = 0; k < 300; k++) begin
      @(negedge sys_clk);
      if (table_loading === 1'b1) n++;
      else if (n > 0) break;
    end
    chk(n, LOAD_CYCLES, "load len");
    rd(OFS_CTL, d);
    chk(d, 32'h80060055, "load bit");
    rd(OFS_STS, d);
    chk(d, 32'h0, "pend clr");
  endtask

  // negotiation flag follows the input level
  task automatic t_negotiate();
    @(posedge sys_clk);
    negotiating <= 1'b1;
    rd(OFS_STS, d);
    chk(d, 32'h00020000, "neg on");
    @(posedge sys_clk);
    negotiating <= 1'b0;
    rd(OFS_STS, d);
    chk(d, 32'h0, "neg off");
  endtask

  // eeprom replaces slots, a second reset restores the capability and control words
  task automatic t_eeprom_reset();
    @(posedge sys_clk);
    eeprom_time_slots <= 7'h2A;
    eeprom_load_valid <= 1'b1;
    @(posedge sys_clk);
    eeprom_load_valid <= 1'b0;
    eeprom_time_slots <= 7'h55;
    rd(OFS_CAP, d);
    chk(d, 32'h042A0019, "eeprom");
    do_reset();
    rd(OFS_CAP, d);
    chk(d, 32'h047F0019, "cap rst2");
    rd(OFS_CTL, d);
    chk(d, 32'h800000FF, "ctl rst2");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    n_errors          = 0;
    check_count       = 0;
    cyc               = 0;
    arst_n            = 1'b0;
    avs_address       = '0;
    avs_read          = 1'b0;
    avs_write         = 1'b0;
    avs_byteenable    = 4'h0;
    avs_writedata     = '0;
    arb_table_write   = 1'b0;
    negotiating       = 1'b0;
    eeprom_load_valid = 1'b0;
    eeprom_time_slots = 7'h00;
    do_reset();
    t_reset_values();
    t_read_only();
    t_select();
    t_lanes();
    t_table_load();
    t_negotiate();
    t_eeprom_reset();
    end_sim();
  end
endmodule
`default_nettype wire

/* vcr_load_if.sv */
// handshake between the register bank and the table loader
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface vcr_load_if;
  logic load_req;  // one-cycle request to apply the table
  logic busy;      // loader is walking the table
  logic done;      // one-cycle pulse, table applied

  // ==========================================================
  // register bank side
  modport ctrl (output load_req, input busy, input done);
  // loader side
  modport loader (input load_req, output busy, output done);
endinterface
`default_nettype wire

/* vcr_pkg.sv */
// constants, field layouts and types of the channel-zero resource registers
// assumes a 32-bit avalon-mm slave with byte addresses, one clock domain
//
// How it works
// - capability arbitration field reads 19h, read-only
// - time-based round robin never selectable here
// - capability bit 14 always reads zero
// - capability bit 15 always reads zero
// - time slot field 7Fh, eeprom load replaces
// - table offset field reads 04h, sixteen-byte units
// - writable class map, one bit per class
// - load bit triggers table load, reads zero
// - select keeps 000b or 011b, else default
// - channel identifier reads 000b, read-only
// - channel enable bit 31, resets to one
// - pending set on table write, load clears
// - negotiation pending mirrors negotiation in progress
package vcr_pkg;

  // ==========================================================
  // bus geometry and register offsets
  localparam int          ADDR_W   = 12;       // byte address width
  localparam int          DATA_W   = 32;       // data word width
  localparam logic [11:0] OFS_CAP  = 12'h150;  // resource capability
  localparam logic [11:0] OFS_CTL  = 12'h154;  // resource control
  localparam logic [11:0] OFS_STS  = 12'h158;  // resource status

  // ==========================================================
  // field positions
  localparam int BIT_LOAD   = 16;  // table load trigger
  localparam int BIT_SEL_LO = 17;  // arbitration select low bit
  localparam int BIT_ENABLE = 31;  // channel enable
  localparam int BIT_PEND   = 16;  // table pending in status
  localparam int BIT_NEG    = 17;  // negotiation pending in status

  // ==========================================================
  // fixed and reset values
  localparam logic [7:0] CAP_ARB_VAL = 8'h19;  // rr, wrr128, twrr128
  localparam logic [6:0] SLOTS_RST   = 7'h7F;  // time slots minus one
  localparam logic [7:0] TBL_OFS_VAL = 8'h04;  // table offset
  localparam logic [7:0] TC_MAP_RST  = 8'hFF;  // all classes mapped
  localparam logic [2:0] SEL_DEFAULT = 3'h0;   // default scheme
  localparam logic [2:0] SEL_WRR     = 3'h3;   // weighted rr 128 phase
  localparam logic [2:0] CHAN_ID_VAL = 3'h0;   // channel identifier
  localparam logic       ENABLE_RST  = 1'b1;   // channel on at reset

  // ==========================================================
  // table load sequencing
  localparam int         LOAD_CYCLES = 128;      // one entry per cycle
  localparam int         LOAD_CNT_W  = 8;        // counter width
  localparam logic [7:0] LOAD_LAST   = 8'h7F;    // LOAD_CYCLES - 1

  // register selected by an address
  typedef enum logic [1:0] {
    VCR_REG_NONE,
    VCR_REG_CAP,
    VCR_REG_CTL,
    VCR_REG_STS
  } vcr_reg_e;

  // loader states
  typedef enum logic {
    VCR_LD_IDLE,
    VCR_LD_RUN
  } vcr_ld_state_e;

endpackage

/* vcr_regs.sv */
// channel-zero resource capability, control and status registers
// assumes an avalon-mm master on sys_clk and same-clock event inputs
`timescale 1ns/1ps
`default_nettype none
module vcr_regs (
  input  wire logic                        sys_clk,
  input  wire logic                        arst_n,
  input  wire logic [vcr_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [3:0]                  avs_byteenable,
  input  wire logic [vcr_pkg::DATA_W-1:0]  avs_writedata,
  output var  logic [vcr_pkg::DATA_W-1:0]  avs_readdata,
  output var  logic                        avs_waitrequest,
  input  wire logic                        arb_table_write,
  input  wire logic                        negotiating,
  input  wire logic                        eeprom_load_valid,
  input  wire logic [6:0]                  eeprom_time_slots,
  output var  logic [7:0]                  class_to_channel_map,
  output var  logic [2:0]                  arb_select,
  output var  logic                        channel_zero_enable,
  output var  logic                        table_load_start,
  output var  logic                        table_loading
);
  import vcr_pkg::*;

  // ==========================================================
  // decode helpers

  // map a byte address onto a register; misaligned is unmapped
  function automatic vcr_reg_e reg_decode(
    input logic [ADDR_W-1:0] a
  );
    vcr_reg_e r;
    r = VCR_REG_NONE;
    case (a)
      OFS_CAP: r = VCR_REG_CAP;
      OFS_CTL: r = VCR_REG_CTL;
      OFS_STS: r = VCR_REG_STS;
      default: r = VCR_REG_NONE;
    endcase
    return r;
  endfunction

  // fold unsupported select codes onto the default scheme;
  // time-based wrr belongs to the other channel only
  function automatic logic [2:0] sel_fold(input logic [2:0] v);
    logic [2:0] s;
    s = SEL_DEFAULT;
    if (v == SEL_WRR) begin
      s = SEL_WRR;
    end
    return s;
  endfunction

  // ==========================================================
  // storage

  logic        ack_q;      // second cycle of an access
  logic [31:0] rdata_q;    // captured read word
  logic [31:0] rdata_d;    // read word being assembled
  logic [7:0]  tc_map_q;   // class to channel map
  logic [2:0]  sel_q;      // folded arbitration select
  logic        enable_q;   // channel enable
  logic [6:0]  slots_q;    // time slot count minus one
  logic        pend_q;     // table written, not yet applied
  logic        neg_q;      // negotiation in progress
  logic        load_q;     // one-cycle load request
  vcr_reg_e    reg_sel;    // register under access
  logic        req;        // read or write asserted
  logic        wr_fire;    // write takes effect this edge
  logic        wr_ctl;     // write to control takes effect

  vcr_load_if  ld();       // link to the table loader

  // ==========================================================
  // bus handshake

  assign reg_sel = reg_decode(avs_address);
  assign req     = avs_read || avs_write;

  // every access stalls exactly one cycle so read data can come
  // from a flop; costs bus rate, buys a clean timing path
  assign avs_waitrequest = req && !ack_q;
  assign wr_fire         = avs_write && ack_q;
  assign wr_ctl          = wr_fire && (reg_sel == VCR_REG_CTL);

  // ack toggles high for the completing cycle only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // ==========================================================
  // read word assembly; reserved fields are constant zero
  always_comb begin
    rdata_d = '0;
    case (reg_sel)
      VCR_REG_CAP: begin
        rdata_d = {TBL_OFS_VAL,
                   1'b0,
                   slots_q,
                   1'b0,
                   1'b0,
                   6'h00,
                   CAP_ARB_VAL};
      end
      VCR_REG_CTL: begin
        rdata_d = {enable_q,
                   4'h0,
                   CHAN_ID_VAL,
                   4'h0,
                   sel_q,
                   1'b0,
                   8'h00,
                   tc_map_q};
      end
      VCR_REG_STS: begin
        rdata_d = {14'h0000,
                   neg_q,
                   pend_q,
                   16'h0000};
      end
      default: rdata_d = '0;      // unmapped reads as zero
    endcase
  end

  // capture on the stall cycle; holds through the answer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else if (avs_read && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;

  // ==========================================================
  // control register fields, per byte lane

  // class map lives in lane 0
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tc_map_q <= TC_MAP_RST;
    end else if (wr_ctl && avs_byteenable[0]) begin
      tc_map_q <= avs_writedata[7:0];
    end
  end

  // select lives in lane 2, folded at write time
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_q <= SEL_DEFAULT;
    end else if (wr_ctl && avs_byteenable[2]) begin
      sel_q <= sel_fold(avs_writedata[BIT_SEL_LO+:3]);
    end
  end

  // enable in lane 3; drives channel_zero_enable, so writing zero shuts the channel
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_q <= ENABLE_RST;
    end else if (wr_ctl && avs_byteenable[3]) begin
      enable_q <= avs_writedata[BIT_ENABLE];
    end
  end

  // load trigger is a pulse, never stored as readable state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      load_q <= 1'b0;
    end else begin
      load_q <= wr_ctl && avs_byteenable[2]
                && avs_writedata[BIT_LOAD];
    end
  end

  assign ld.load_req = load_q;

  // ==========================================================
  // capability time slots, replaced by eeprom auto-load
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      slots_q <= SLOTS_RST;
    end else if (eeprom_load_valid) begin
      slots_q <= eeprom_time_slots;
    end
  end

  // ==========================================================
  // status flags

  // a table write in the cycle the load ends keeps pending set
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
    end else if (arb_table_write) begin
      pend_q <= 1'b1;
    end else if (ld.done) begin
      pend_q <= 1'b0;
    end
  end

  // one flop of registering keeps the read path short
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      neg_q <= 1'b0;
    end else begin
      neg_q <= negotiating;
    end
  end

  // ==========================================================
  // table loader

  vcr_table_loader i_vcr_table_loader (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .ld      (ld)
  );

  // ==========================================================
  // outputs toward the switch core
  assign class_to_channel_map = tc_map_q;
  assign arb_select           = sel_q;
  assign channel_zero_enable  = enable_q;
  assign table_load_start     = load_q;
  assign table_loading        = ld.busy;

  // ==========================================================
  // checks

  property p_cap_arb;
    @(posedge sys_clk) disable iff (!arst_n)
      (avs_read && !avs_waitrequest && reg_sel == VCR_REG_CAP)
      |-> avs_readdata[7:0] == 8'h19;
  endproperty
  a_cap_arb: assert property (p_cap_arb)
    else $error("capability arbitration field wrong");

  property p_no_timed;
    @(posedge sys_clk) disable iff (!arst_n)
      arb_select == 3'h0 || arb_select == 3'h3;
  endproperty
  a_no_timed: assert property (p_no_timed)
    else $error("unsupported arbitration scheme selected");

  property p_cap_hi_zero;
    @(posedge sys_clk) disable iff (!arst_n)
      (avs_read && !avs_waitrequest && reg_sel == VCR_REG_CAP)
      |-> avs_readdata[15:14] == 2'b00 && avs_readdata[31:24] == 8'h04;
  endproperty
  a_cap_hi_zero: assert property (p_cap_hi_zero)
    else $error("capability flags or table offset wrong");

  property p_slots_load;
    @(posedge sys_clk) disable iff (!arst_n)
      eeprom_load_valid |=> slots_q == $past(eeprom_time_slots);
  endproperty
  a_slots_load: assert property (p_slots_load)
    else $error("time slot field missed eeprom load");

  property p_map_write;
    @(posedge sys_clk) disable iff (!arst_n)
      (wr_ctl && avs_byteenable[0])
      |=> class_to_channel_map == $past(avs_writedata[7:0]);
  endproperty
  a_map_write: assert property (p_map_write)
    else $error("class map did not take write");

  property p_load_pulse;
    @(posedge sys_clk) disable iff (!arst_n)
      (wr_ctl && avs_byteenable[2] && avs_writedata[16])
      |=> table_load_start ##1 (!table_load_start && table_loading);
  endproperty
  a_load_pulse: assert property (p_load_pulse)
    else $error("load trigger did not start the loader");

  property p_ctl_read;
    @(posedge sys_clk) disable iff (!arst_n)
      (avs_read && !avs_waitrequest && reg_sel == VCR_REG_CTL)
      |-> !avs_readdata[16] && avs_readdata[26:24] == 3'h0
          && avs_readdata[15:8] == 8'h00;
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control read shows trigger, id or reserved bits");

  property p_sel_write;
    @(posedge sys_clk) disable iff (!arst_n)
      (wr_ctl && avs_byteenable[2])
      |=> arb_select == (($past(avs_writedata[19:17]) == 3'h3)
                         ? 3'h3 : 3'h0);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("select write not folded correctly");

  property p_enable_write;
    @(posedge sys_clk) disable iff (!arst_n)
      (wr_ctl && avs_byteenable[3])
      |=> channel_zero_enable == $past(avs_writedata[31]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable did not take write");

  property p_pend_set;
    @(posedge sys_clk) disable iff (!arst_n)
      arb_table_write |=> pend_q;
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("table write did not set pending");

  property p_pend_clear;
    @(posedge sys_clk) disable iff (!arst_n)
      (ld.done && !arb_table_write) |=> !pend_q;
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("pending not cleared by finished load");

  property p_neg_read;
    @(posedge sys_clk) disable iff (!arst_n)
      (avs_read && !avs_waitrequest && reg_sel == VCR_REG_STS)
      |-> avs_readdata[17] == $past(neg_q)
          && avs_readdata[15:0] == 16'h0000;
  endproperty
  a_neg_read: assert property (p_neg_read)
    else $error("status read wrong");

  property p_one_stall;
    @(posedge sys_clk) disable iff (!arst_n)
      (req && !ack_q) |=> (req |-> !avs_waitrequest);
  endproperty
  a_one_stall: assert property (p_one_stall)
    else $error("access not answered after one stall");

endmodule
`default_nettype wire

/* vcr_table_loader.sv */
// sequencer that applies the programmed port arbitration table
// assumes table storage is read one entry per clock while busy
`timescale 1ns/1ps
`default_nettype none
module vcr_table_loader (
  input  wire logic   sys_clk,
  input  wire logic   arst_n,
  vcr_load_if.loader  ld
);
  import vcr_pkg::*;

  vcr_ld_state_e         state_q;  // loader state
  logic [LOAD_CNT_W-1:0] cnt_q;    // entry index
  logic                  done_q;   // completion pulse

  // ==========================================================
  // walk the table; a new request restarts so late entries count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= VCR_LD_IDLE;
      cnt_q   <= '0;
    end else if (ld.load_req) begin
      state_q <= VCR_LD_RUN;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        VCR_LD_IDLE: cnt_q <= '0;
        VCR_LD_RUN: begin
          if (cnt_q == LOAD_LAST) begin
            state_q <= VCR_LD_IDLE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: state_q <= VCR_LD_IDLE;
      endcase
    end
  end

  // ==========================================================
  // done pulses once, in the cycle busy falls
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == VCR_LD_RUN) && (cnt_q == LOAD_LAST)
                && !ld.load_req;
    end
  end

  assign ld.busy = (state_q == VCR_LD_RUN);
  assign ld.done = done_q;

  // a load always finishes in bounded time
  property p_load_ends;
    @(posedge sys_clk) disable iff (!arst_n)
      ld.load_req |-> ##[1:130] (ld.done || ld.load_req);
  endproperty
  a_load_ends: assert property (p_load_ends)
    else $error("table load did not complete");

endmodule
`default_nettype wire
